// >>> testbench/iprf_regs_sva.sv
// Concurrent checks on the ports of the priority and flag register block.
`timescale 1ns/100ps
`default_nettype none
module iprf_regs_sva (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side.
  input wire logic nestingDisable,
  input wire logic altTableSelect,
  input wire iprf_pkg::iprf_level_t cpuLevel,
  input wire logic userIrqBlocked,
  input wire logic irqTake,
  input wire logic [6:0] irqVecNum,
  input wire logic [23:0] irqVecAddr,
  input wire logic irq
);
  import iprf_pkg::*;
  // ********
  // Checks
  // ********
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_level_block: assert property (
    userIrqBlocked == (cpuLevel[3] | (&cpuLevel[2:0])))
    else $error("blocked flag disagrees with level");
  chk_high_clear: assert property (
    !$rose(cpuLevel[3])) else $error("high priority bit was set");
  chk_vec_addr: assert property (
    irqTake && $stable(altTableSelect) |-> irqVecAddr ==
    (altTableSelect ? 24'h000104 : 24'h000004) + {16'h0, irqVecNum, 1'h0})
    else $error("vector address wrong");
  chk_no_take: assert property (
    $past(userIrqBlocked) && userIrqBlocked |-> !irqTake)
    else $error("request taken while blocked");
  chk_field_frozen: assert property (
    (nestingDisable && !irqTake) [*2] |=> $stable(cpuLevel[2:0]))
    else $error("priority field moved while nesting disabled");
  chk_rd_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write answer late");
  chk_rd_done: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  cover property (irqTake && altTableSelect);
  cover property (irq);
  cover property (userIrqBlocked);
endmodule : iprf_regs_sva
bind iprf_regs iprf_regs_sva chk (.*);
`default_nettype wire

// >>> testbench/iprf_src_model.sv
// Model of the core and the peripheral request sources.
`timescale 1ns/100ps
`default_nettype none
module iprf_src_model (
  // Clock.
  input wire logic core_clk,
  // Commands from the bench.
  input wire logic [35:0] fireCmd,
  input wire logic disiCmd,
  // Events into the block.
  output logic [3:0] trapEvent = 4'h0,
  output logic [15:0] reqEvent0 = 16'h0,
  output logic [15:0] reqEvent1 = 16'h0,
  output logic irqDisableInstrActive = 1'h0
);
  // Sources only raise events; clearing flags is left to software.
  always @(posedge core_clk) begin
    {trapEvent, reqEvent1, reqEvent0} <= fireCmd;
    irqDisableInstrActive <= disiCmd;
  end
endmodule : iprf_src_model
`default_nettype wire

// >>> testbench/tb_irq_priority_and_flag_regs.sv
// Self-checking bench for the priority and flag register block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_irq_priority_and_flag_regs;
  import iprf_pkg::*;
  logic core_clk = 1'h0, rst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, srcEnable = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, trapEvent;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, disiCmd = 1'h0;
  logic [95:0] srcPriority = 96'h0;
  logic [35:0] fireCmd = 36'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irqDisableInstrActive, nestingDisable;
  logic altTableSelect, userIrqBlocked, irqTake, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] reqEvent0, reqEvent1;
  logic [2:0] extEdgeSel;
  logic [6:0] irqVecNum;
  logic [23:0] irqVecAddr;
  iprf_level_t cpuLevel, irqNewLevel;
  int cyc = 0, fails = 0, checks = 0;
  iprf_regs dut (.*);
  iprf_src_model src (.*);
  always #2.5 core_clk = ~core_clk;
  // ********
  // Helpers
  // ********
  task automatic give_verdict();
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic wt();
    repeat (3) @(posedge core_clk);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
    input logic [1:0] er = 2'h0);
    logic pa, pw, b;
    pa = 1'h0;
    pw = 1'h0;
    b = 1'h0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!b) begin
      @(negedge core_clk);
      pa = pa | s_axi_awready;
      pw = pw | s_axi_wready;
      b = s_axi_bvalid;
      if (b) `CHK("bresp", er, s_axi_bresp)
      @(posedge core_clk);
      if (pa) s_axi_awvalid <= 1'h0;
      if (pw) s_axi_wvalid <= 1'h0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
    input logic [15:0] m = 16'hffff, input logic [1:0] er = 2'h0);
    logic pa, v;
    pa = 1'h0;
    v = 1'h0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    while (!v) begin
      @(negedge core_clk);
      pa = pa | s_axi_arready;
      v = s_axi_rvalid;
      if (v) begin
        `CHK("rdata", {16'h0, e & m}, s_axi_rdata & {16'hffff, m})
        `CHK("rresp", er, s_axi_rresp)
      end
      @(posedge core_clk);
      if (pa) s_axi_arvalid <= 1'h0;
    end
  endtask : rd
  task automatic fire(input logic [35:0] c);
    @(posedge core_clk);
    fireCmd <= c;
    @(posedge core_clk);
    fireCmd <= 36'h0;
    wt();
  endtask : fire
  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 16'h0);
  endtask : t_reset
  task automatic t_prio();
    wr(8'h00, 16'h00e0);
    rd(8'h00, 16'h00e0, 16'h00e0);
    wt();
    `CHK("level", 4'h7, cpuLevel)
    `CHK("blocked", 1'h1, userIrqBlocked)
    wr(8'h04, 16'h0008);
    rd(8'h04, 16'h0000, 16'h0008);
    wr(8'h00, 16'h0020);
    wt();
    `CHK("level", 4'h1, cpuLevel)
    `CHK("blocked", 1'h0, userIrqBlocked)
  endtask : t_prio
  task automatic t_nest();
    wr(8'h08, 16'h8000);
    rd(8'h08, 16'h8000);
    `CHK("nest", 1'h1, nestingDisable)
    wr(8'h00, 16'h00c0);
    rd(8'h00, 16'h0020, 16'h00e0);
    wr(8'h08, 16'h0000);
    wr(8'h00, 16'h00c0);
    rd(8'h00, 16'h00c0, 16'h00e0);
  endtask : t_nest
  task automatic t_vect();
    wr(8'h0c, 16'hffff);
    disiCmd <= 1'h1;
    rd(8'h0c, 16'hc007);
    `CHK("alt", 1'h1, altTableSelect)
    `CHK("edge", 3'h7, extEdgeSel)
    disiCmd <= 1'h0;
    rd(8'h0c, 16'h8007);
    wr(8'h0c, 16'h0000);
    rd(8'h0c, 16'h0000);
  endtask : t_vect
  task automatic t_flags();
    wr(8'h10, 16'hffff);
    rd(8'h10, 16'h3fef);
    wr(8'h14, 16'hffff);
    rd(8'h14, 16'h381f);
    wr(8'h08, 16'h7fff);
    rd(8'h08, 16'h001e);
    for (int i = 2; i < 6; i++) wr(8'(i * 4), 16'h0);
    fire({4'hf, 16'hffff, 16'hffff});
    rd(8'h10, 16'h3fef);
    rd(8'h14, 16'h381f);
    rd(8'h08, 16'h001e);
    for (int i = 2; i < 6; i++) wr(8'(i * 4), 16'h0);
    rd(8'h10, 16'h0000);
  endtask : t_flags
  task automatic t_irq();
    wr(8'h20, 16'h0003);
    wr(8'h1c, 16'h0001);
    wt();
    `CHK("irq", 1'h0, irq)
    fire({20'h0, 16'h0008});
    `CHK("irq", 1'h1, irq)
    rd(8'h18, 16'h0001, 16'h0001);
    wr(8'h1c, 16'h0000);
    wt();
    `CHK("irq", 1'h0, irq)
    wr(8'h1c, 16'h0001);
    wt();
    `CHK("irq", 1'h1, irq)
    wr(8'h20, 16'h0001);
    wt();
    `CHK("irq", 1'h0, irq)
    rd(8'h20, 16'h0000);
    wr(8'h40, 16'h0000, 2'h2);
    rd(8'h40, 16'h0000, 16'hffff, 2'h2);
  endtask : t_irq
  task automatic t_take();
    srcEnable <= 32'h8;
    srcPriority <= 96'h800;
    wt();
    `CHK("take", 1'h0, irqTake)
    wr(8'h00, 16'h0060);
    wt();
    `CHK("take", 1'h1, irqTake)
    `CHK("vecnum", 7'h0b, irqVecNum)
    `CHK("vecaddr", 24'h00001a, irqVecAddr)
    `CHK("newlevel", 4'h4, irqNewLevel)
    wr(8'h0c, 16'h8000);
    wt();
    `CHK("vecaddr", 24'h00011a, irqVecAddr)
    wr(8'h08, 16'h8000);
    wt();
    `CHK("level", 4'h4, cpuLevel)
    `CHK("take", 1'h0, irqTake)
    wr(8'h08, 16'h0000);
    wr(8'h00, 16'h0080);
    wt();
    `CHK("take", 1'h0, irqTake)
  endtask : t_take
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    t_reset();
    t_prio();
    t_nest();
    t_vect();
    t_flags();
    t_irq();
    t_take();
    give_verdict();
  end
endmodule : tb_irq_priority_and_flag_regs
`default_nettype wire

// >>> verilog/iprf_arb_if.sv
// Carrier between the register file and the request arbiter.
`timescale 1ns/100ps
`default_nettype none
interface iprf_arb_if;
  logic [31:0] pending;
  logic [31:0] enabled;
  logic [95:0] priorities;
  iprf_pkg::iprf_level_t cpuLevel;
  logic altTable;
  logic take;
  logic [6:0] vecNum;
  logic [23:0] vecAddr;
  iprf_pkg::iprf_level_t newLevel;

  modport regs (output pending, output enabled, output priorities,
    output cpuLevel, output altTable, input take, input vecNum,
    input vecAddr, input newLevel);
  modport arb (input pending, input enabled, input priorities,
    input cpuLevel, input altTable, output take, output vecNum,
    output vecAddr, output newLevel);
endinterface : iprf_arb_if
`default_nettype wire

// >>> verilog/iprf_arbiter.sv
// Picks the highest request that beats the CPU level and forms its vector.
`timescale 1ns/100ps
`default_nettype none
`include "iprf_defines.svh"
module iprf_arbiter (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Register side.
  iprf_arb_if.arb arb
);
  import iprf_pkg::*;

  typedef struct packed {
    logic take;
    logic [6:0] vecNum;
    logic [23:0] vecAddr;
    iprf_level_t newLevel;
  } iprf_arb_s;

  iprf_arb_s state_q;
  iprf_arb_s state_d;

  // Lower request numbers win among equal priorities.
  always_comb begin
    logic found;
    logic [2:0] best;
    logic [6:0] idx;
    found = 1'b0;
    best = 3'h0;
    idx = 7'h00;
    state_d = '0;
    for (int i = 0; i < 32; i++) begin
      if (arb.pending[i] && arb.enabled[i] &&
          {1'b0, arb.priorities[3*i +: 3]} > arb.cpuLevel &&
          (!found || arb.priorities[3*i +: 3] > best)) begin
        found = 1'b1;
        best = arb.priorities[3*i +: 3];
        idx = 7'(i);
      end
    end
    state_d.take = found;
    state_d.vecNum = idx + `IPRF_USER_VEC0;
    state_d.newLevel = {1'b0, best};
    state_d.vecAddr = (arb.altTable ? `IPRF_ALT_BASE : `IPRF_VEC_BASE)
      + {16'h0000, state_d.vecNum, 1'b0};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign arb.take = state_q.take;
  assign arb.vecNum = state_q.vecNum;
  assign arb.vecAddr = state_q.vecAddr;
  assign arb.newLevel = state_q.newLevel;
endmodule : iprf_arbiter
`default_nettype wire

// >>> verilog/iprf_defines.svh
// Register offsets, field positions and reset values of the priority block.
`ifndef IPRF_DEFINES_SVH
`define IPRF_DEFINES_SVH

`define IPRF_OFF_STATUS   8'h00
`define IPRF_OFF_CORE     8'h04
`define IPRF_OFF_NEST     8'h08
`define IPRF_OFF_VECT     8'h0c
`define IPRF_OFF_FLAGS0   8'h10
`define IPRF_OFF_FLAGS1   8'h14
`define IPRF_OFF_IRQSTAT  8'h18
`define IPRF_OFF_IRQEN    8'h1c
`define IPRF_OFF_IRQCLR   8'h20

`define IPRF_PRIO_LSB     5
`define IPRF_PRIO_MSB     7
`define IPRF_HIGH_BIT     3
`define IPRF_NEST_BIT     15
`define IPRF_TRAP_LSB     1
`define IPRF_TRAP_MSB     4
`define IPRF_ALT_BIT      15
`define IPRF_IRQ_DISABLE_INSTR_ACTIVE_BIT     14
`define IPRF_EDGE_MSB     2

`define IPRF_FLAGS0_MASK  16'h3fef
`define IPRF_FLAGS1_BIG   16'h381f
`define IPRF_FLAGS1_SMALL 16'h201f
`define IPRF_RESET_ZERO   16'h0000
`define IPRF_VEC_BASE     24'h000004
`define IPRF_ALT_BASE     24'h000104
`define IPRF_USER_VEC0    7'h08

`endif

// >>> verilog/iprf_pkg.sv
// Types shared by the priority and flag register block.
package iprf_pkg;
  typedef enum logic [1:0] {
    IPRF_BUS_IDLE,
    IPRF_BUS_WRESP,
    IPRF_BUS_RDATA
  } iprf_bus_e;

  typedef logic [3:0] iprf_level_t;
endpackage : iprf_pkg

// >>> verilog/iprf_regs.sv
// Interrupt priority, trap and request flag registers with AXI4-Lite slave.
`timescale 1ns/100ps
`default_nettype none
`include "iprf_defines.svh"
module iprf_regs #(
  parameter bit LARGE_MEMORY = 1'b1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Events from the core and peripherals.
  input wire logic [3:0] trapEvent,
  input wire logic [15:0] reqEvent0,
  input wire logic [15:0] reqEvent1,
  input wire logic irqDisableInstrActive,
  // Enables and priorities of the sources, held elsewhere.
  input wire logic [31:0] srcEnable,
  input wire logic [95:0] srcPriority,
  // Controls seen by the core.
  output logic nestingDisable,
  output logic altTableSelect,
  output logic [2:0] extEdgeSel,
  output iprf_pkg::iprf_level_t cpuLevel,
  output logic userIrqBlocked,
  // Request to the core.
  output logic irqTake,
  output logic [6:0] irqVecNum,
  output logic [23:0] irqVecAddr,
  output iprf_pkg::iprf_level_t irqNewLevel,
  // Summary interrupt.
  output logic irq
);
  import iprf_pkg::*;

  localparam logic [15:0] FLAGS1_MASK =
    LARGE_MEMORY ? `IPRF_FLAGS1_BIG : `IPRF_FLAGS1_SMALL;

  typedef struct packed {
    iprf_bus_e wst;
    iprf_bus_e rst;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic haveAw;
    logic haveW;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [2:0] prioField;
    logic prioHigh;
    logic nest;
    logic [3:0] traps;
    logic alt;
    logic [2:0] edges;
    logic [15:0] flags0;
    logic [15:0] flags1;
    logic [1:0] irqStat;
    logic [1:0] irqEn;
  } iprf_regs_s;

  iprf_regs_s state_q;
  iprf_regs_s state_d;
  iprf_arb_if arbBus ();

  // Merges byte lanes of a write into a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  // Read view of a register; unmapped bits are zero.
  function automatic logic [31:0] readWord(input iprf_regs_s s,
      input logic [7:0] addr, input logic irq_disable_instr_active);
    logic [15:0] v;
    v = `IPRF_RESET_ZERO;
    unique case (addr)
      `IPRF_OFF_STATUS: v[`IPRF_PRIO_MSB:`IPRF_PRIO_LSB] = s.prioField;
      `IPRF_OFF_CORE: v[`IPRF_HIGH_BIT] = s.prioHigh;
      `IPRF_OFF_NEST: begin
        v[`IPRF_NEST_BIT] = s.nest;
        v[`IPRF_TRAP_MSB:`IPRF_TRAP_LSB] = s.traps;
      end
      `IPRF_OFF_VECT: begin
        v[`IPRF_ALT_BIT] = s.alt;
        v[`IPRF_IRQ_DISABLE_INSTR_ACTIVE_BIT] = irq_disable_instr_active;
        v[`IPRF_EDGE_MSB:0] = s.edges;
      end
      `IPRF_OFF_FLAGS0: v = s.flags0 & `IPRF_FLAGS0_MASK;
      `IPRF_OFF_FLAGS1: v = s.flags1 & FLAGS1_MASK;
      `IPRF_OFF_IRQSTAT: v[1:0] = s.irqStat;
      `IPRF_OFF_IRQEN: v[1:0] = s.irqEn;
      default: v = `IPRF_RESET_ZERO;
    endcase
    return {16'h0000, v};
  endfunction : readWord

  function automatic logic mapped(input logic [7:0] addr);
    return addr[1:0] == 2'b00 && addr <= `IPRF_OFF_IRQCLR;
  endfunction : mapped

  always_comb begin
    logic doWrite;
    logic [7:0] wa;
    logic [15:0] wv;
    logic [3:0] trapNew;
    logic [15:0] new0;
    logic [15:0] new1;
    logic [1:0] clr;
    state_d = state_q;
    clr = 2'b00;
    wv = 16'h0000;
    doWrite = 1'b0;
    wa = 8'h00;
    trapNew = 4'h0;
    new0 = 16'h0000;
    new1 = 16'h0000;
    // Write channel: address and data taken in either order.
    if (state_q.wst == IPRF_BUS_IDLE) begin
      if (s_axi_awvalid && !state_q.haveAw) begin
        state_d.haveAw = 1'b1;
        state_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state_q.haveW) begin
        state_d.haveW = 1'b1;
        state_d.wdata = s_axi_wdata;
        state_d.wstrb = s_axi_wstrb;
      end
    end
    doWrite = state_d.haveAw && state_d.haveW &&
      state_q.wst == IPRF_BUS_IDLE;
    wa = state_d.awaddr;
    if (doWrite) begin
      state_d.haveAw = 1'b0;
      state_d.haveW = 1'b0;
      state_d.wst = IPRF_BUS_WRESP;
      state_d.bresp = mapped(wa) ? 2'b00 : 2'b10;
      unique case (wa)
        `IPRF_OFF_STATUS: begin
          wv = merge16({8'h00, state_q.prioField, 5'h00},
            state_d.wdata, state_d.wstrb);
          if (!state_q.nest) begin
            state_d.prioField = wv[`IPRF_PRIO_MSB:`IPRF_PRIO_LSB];
          end
        end
        `IPRF_OFF_CORE: begin
          wv = merge16(16'hffff, state_d.wdata, state_d.wstrb);
          state_d.prioHigh = state_q.prioHigh & wv[`IPRF_HIGH_BIT];
        end
        `IPRF_OFF_NEST: begin
          wv = merge16({state_q.nest, 10'h000, state_q.traps, 1'b0},
            state_d.wdata, state_d.wstrb);
          state_d.nest = wv[`IPRF_NEST_BIT];
          state_d.traps = wv[`IPRF_TRAP_MSB:`IPRF_TRAP_LSB];
        end
        `IPRF_OFF_VECT: begin
          wv = merge16({state_q.alt, 12'h000, state_q.edges},
            state_d.wdata, state_d.wstrb);
          state_d.alt = wv[`IPRF_ALT_BIT];
          state_d.edges = wv[`IPRF_EDGE_MSB:0];
        end
        `IPRF_OFF_FLAGS0: begin
          state_d.flags0 = merge16(state_q.flags0, state_d.wdata,
            state_d.wstrb) & `IPRF_FLAGS0_MASK;
        end
        `IPRF_OFF_FLAGS1: begin
          state_d.flags1 = merge16(state_q.flags1, state_d.wdata,
            state_d.wstrb) & FLAGS1_MASK;
        end
        `IPRF_OFF_IRQEN: begin
          if (state_d.wstrb[0]) begin
            state_d.irqEn = state_d.wdata[1:0];
          end
        end
        `IPRF_OFF_IRQCLR: begin
          if (state_d.wstrb[0]) begin
            clr = state_d.wdata[1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (state_q.wst == IPRF_BUS_WRESP && s_axi_bready) begin
      state_d.wst = IPRF_BUS_IDLE;
    end
    // Read channel.
    if (state_q.rst == IPRF_BUS_IDLE && s_axi_arvalid) begin
      state_d.rst = IPRF_BUS_RDATA;
      state_d.rdata = readWord(state_q, s_axi_araddr, irqDisableInstrActive);
      state_d.rresp = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
    end else if (state_q.rst == IPRF_BUS_RDATA && s_axi_rready) begin
      state_d.rst = IPRF_BUS_IDLE;
    end
    // Hardware sets win over software clears in the same cycle.
    trapNew = trapEvent & ~state_d.traps;
    state_d.traps = state_d.traps | trapEvent;
    new0 = reqEvent0 & `IPRF_FLAGS0_MASK & ~state_d.flags0;
    new1 = reqEvent1 & FLAGS1_MASK & ~state_d.flags1;
    state_d.flags0 = state_d.flags0 | (reqEvent0 & `IPRF_FLAGS0_MASK);
    state_d.flags1 = state_d.flags1 | (reqEvent1 & FLAGS1_MASK);
    if (irqTake && state_q.nest) begin
      state_d.prioField = irqNewLevel[2:0];
    end
    state_d.irqStat = (state_q.irqStat & ~clr) |
      {|trapNew, |new0 | |new1};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Request numbers follow the flag layout: word 0 then word 1.
  assign arbBus.pending = {state_q.flags1, state_q.flags0};
  assign arbBus.enabled = srcEnable;
  assign arbBus.priorities = srcPriority;
  assign arbBus.cpuLevel = {state_q.prioHigh, state_q.prioField};
  assign arbBus.altTable = state_q.alt;

  iprf_arbiter u_arbiter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .arb(arbBus.arb)
  );

  assign irqTake = arbBus.take;
  assign irqVecNum = arbBus.vecNum;
  assign irqVecAddr = arbBus.vecAddr;
  assign irqNewLevel = arbBus.newLevel;

  assign s_axi_awready = state_q.wst == IPRF_BUS_IDLE && !state_q.haveAw;
  assign s_axi_wready = state_q.wst == IPRF_BUS_IDLE && !state_q.haveW;
  assign s_axi_bvalid = state_q.wst == IPRF_BUS_WRESP;
  assign s_axi_bresp = state_q.bresp;
  assign s_axi_arready = state_q.rst == IPRF_BUS_IDLE;
  assign s_axi_rvalid = state_q.rst == IPRF_BUS_RDATA;
  assign s_axi_rdata = state_q.rdata;
  assign s_axi_rresp = state_q.rresp;

  assign nestingDisable = state_q.nest;
  assign altTableSelect = state_q.alt;
  assign extEdgeSel = state_q.edges;
  assign cpuLevel = {state_q.prioHigh, state_q.prioField};
  assign userIrqBlocked = state_q.prioHigh ||
    state_q.prioField == 3'h7;
  assign irq = |(state_q.irqStat & state_q.irqEn);
endmodule : iprf_regs
`default_nettype wire
